//--- rtl/ipsf_port_fsm.v
// Exchange-side port status state machine for one ISDN user port
`default_nettype none
`include "ipsf_defs.vh"
module ipsf_port_fsm (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   rst,
  // Provisioning
  input  wire                   perf_mon_enable,
  // Management requests, one-cycle pulses
  input  wire                   mgmt_unblock_request,
  input  wire                   mgmt_block_indication,
  input  wire                   sig_channel_block_request,
  input  wire                   sig_channel_unblock_request,
  // Received element from peer
  input  wire                   rx_valid,
  input  wire [`IPSF_CFE_W-1:0] rx_code,
  // Transmitted element to peer
  output wire                   tx_valid,
  output wire [`IPSF_CFE_W-1:0] tx_code,
  // Management reports, one-cycle pulses
  output reg                    mgmt_unblock_req_out_q,
  output reg                    mgmt_block_ind_out_q,
  output reg                    mgmt_unblock_indication_q,
  output reg                    activation_indication_q,
  output reg                    deactivation_indication_q,
  output reg                    mgmt_block_request_report_q,
  output reg                    grading_indication_q,
  output reg                    terminal_out_of_service_ind_q,
  output reg                    network_failure_ind_q,
  // State
  output wire [`IPSF_ST_W-1:0]  port_state
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  wire ev_unblock;
  wire ev_block;
  wire ev_block_req;
  wire ev_grading;
  wire ev_te_oos;
  wire ev_net_fail;
  wire ev_other;

  ipsf_cfe_decode u_dec (
    .rx_valid     (rx_valid),
    .rx_code      (rx_code),
    .ev_unblock   (ev_unblock),
    .ev_block     (ev_block),
    .ev_block_req (ev_block_req),
    .ev_grading   (ev_grading),
    .ev_te_oos    (ev_te_oos),
    .ev_net_fail  (ev_net_fail),
    .ev_other     (ev_other)
  );

  // ****************************************************************
  // Behaviour by event and state
  // ****************************************************************
  // Management unblock:
  //   blocked         send unblock, go to local unblock
  //   local unblock   send unblock, stay
  //   remote unblock  send unblock, raise activation, go operational
  //   operational     send unblock, stay; the peer's answer confirms alignment
  // Management block:
  //   any state       send block, go to blocked
  // Received unblock:
  //   blocked         ask management to unblock, go to remote unblock
  //   local unblock   raise activation, go operational
  //   remote unblock  ask management to unblock again, stay
  //   operational     report unblock indication, stay
  // Received block:
  //   blocked         nothing
  //   other states    report block; operational also raises deactivation
  // Received block request and grading:
  //   operational     report to management, stay; grading only when provisioned
  //   other states    dropped
  // Received terminal out of service and network failure:
  //   blocked, local  forward to management, stay
  //   other states    dropped
  // Signalling-channel block and unblock requests:
  //   operational     send the matching element, stay
  //   other states    dropped
  // Reserved or unknown codes are dropped in every state.
  // Activation codes belong to the access machine, not to this one:
  // they are treated here like any other code that this machine
  // neither sends nor takes.
  // Only one event is taken per cycle. When several arrive together,
  // management block wins, then management unblock, then the
  // signalling-channel requests, then the received element; the
  // losers are dropped, so management must not stack its requests.

  // ****************************************************************
  // State machine
  // ****************************************************************
  localparam [`IPSF_ST_W-1:0] ST_BLK = `IPSF_ST_BLOCKED;
  localparam [`IPSF_ST_W-1:0] ST_LUB = `IPSF_ST_LOCAL_UB;
  localparam [`IPSF_ST_W-1:0] ST_RUB = `IPSF_ST_REMOTE_UB;
  localparam [`IPSF_ST_W-1:0] ST_OPR = `IPSF_ST_OPER;

  reg  [`IPSF_ST_W-1:0]  state_q;
  reg  [`IPSF_ST_W-1:0]  state_d;
  reg                    send_d;
  reg  [`IPSF_CFE_W-1:0] code_d;
  reg                    ubr_d;
  reg                    bi_d;
  reg                    ubi_d;
  reg                    ai_d;
  reg                    di_d;
  reg                    br_d;
  reg                    gi_d;
  reg                    uf_d;
  reg                    nf_d;

  assign port_state = state_q;

  // A state code outside the four legal ones falls back to blocked
  wire state_legal = (state_q == ST_BLK) || (state_q == ST_LUB) ||
                     (state_q == ST_RUB) || (state_q == ST_OPR);

  // Next state and outputs; management requests take priority over received elements
  always @* begin
    state_d = state_q;
    send_d  = 1'b0;
    code_d  = `IPSF_CFE_UNBLOCK;
    ubr_d   = 1'b0;
    bi_d    = 1'b0;
    ubi_d   = 1'b0;
    ai_d    = 1'b0;
    di_d    = 1'b0;
    br_d    = 1'b0;
    gi_d    = 1'b0;
    uf_d    = 1'b0;
    nf_d    = 1'b0;
    if (!state_legal) begin
      state_d = ST_BLK;
    end else if (mgmt_block_indication) begin
      send_d  = 1'b1;
      code_d  = `IPSF_CFE_BLOCK;
      state_d = ST_BLK;
    end else if (mgmt_unblock_request) begin
      send_d = 1'b1;
      code_d = `IPSF_CFE_UNBLOCK;
      case (state_q)
        ST_BLK: begin
          state_d = ST_LUB;
        end
        ST_RUB: begin
          ai_d    = 1'b1;
          state_d = ST_OPR;
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end else if (sig_channel_block_request || sig_channel_unblock_request) begin
      if (state_q == ST_OPR) begin
        send_d = 1'b1;
        code_d = sig_channel_block_request ? `IPSF_CFE_SIG_BLOCK : `IPSF_CFE_SIG_UNBLOCK;
      end
    end else if (ev_unblock) begin
      case (state_q)
        ST_BLK: begin
          ubr_d   = 1'b1;
          state_d = ST_RUB;
        end
        ST_LUB: begin
          ai_d    = 1'b1;
          state_d = ST_OPR;
        end
        ST_RUB: begin
          ubr_d = 1'b1;
        end
        ST_OPR: begin
          ubi_d = 1'b1;
        end
        default: begin
          state_d = ST_BLK;
        end
      endcase
    end else if (ev_block) begin
      if (state_q != ST_BLK) begin
        bi_d    = 1'b1;
        di_d    = (state_q == ST_OPR);
        state_d = ST_BLK;
      end
    end else if (state_q == ST_OPR) begin
      br_d = ev_block_req;
      gi_d = ev_grading && perf_mon_enable;
    end else if (state_q == ST_BLK || state_q == ST_LUB) begin
      uf_d = ev_te_oos;
      nf_d = ev_net_fail;
    end
    // Reserved codes and ev_other fall through with no effect
  end

  // State register, starts blocked
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_BLK;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Report pulses
  // ****************************************************************
  // Report bit positions, highest first
  localparam integer RPT_N   = 9;
  localparam integer RPT_UBR = 8;
  localparam integer RPT_BI  = 7;
  localparam integer RPT_UBI = 6;
  localparam integer RPT_AI  = 5;
  localparam integer RPT_DI  = 4;
  localparam integer RPT_BR  = 3;
  localparam integer RPT_GI  = 2;
  localparam integer RPT_UF  = 1;
  localparam integer RPT_NF  = 0;

  wire [RPT_N-1:0] rpt_d;
  reg  [RPT_N-1:0] rpt_q;

  // Gather next report pulses into one vector
  assign rpt_d[RPT_UBR] = ubr_d;
  assign rpt_d[RPT_BI]  = bi_d;
  assign rpt_d[RPT_UBI] = ubi_d;
  assign rpt_d[RPT_AI]  = ai_d;
  assign rpt_d[RPT_DI]  = di_d;
  assign rpt_d[RPT_BR]  = br_d;
  assign rpt_d[RPT_GI]  = gi_d;
  assign rpt_d[RPT_UF]  = uf_d;
  assign rpt_d[RPT_NF]  = nf_d;

  // One flip-flop per report pulse; each pulse stands one cycle only,
  // so management must take it on the edge after it rises
  genvar rpt_i;
  generate
    for (rpt_i = 0; rpt_i < RPT_N; rpt_i = rpt_i + 1) begin : g_rpt
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          rpt_q[rpt_i] <= 1'b0;
        end else begin
          rpt_q[rpt_i] <= rpt_d[rpt_i];
        end
      end
    end
  endgenerate

  // Drive the report ports straight from their flip-flops
  always @* begin
    mgmt_unblock_req_out_q        = rpt_q[RPT_UBR];
    mgmt_block_ind_out_q          = rpt_q[RPT_BI];
    mgmt_unblock_indication_q     = rpt_q[RPT_UBI];
    activation_indication_q       = rpt_q[RPT_AI];
    deactivation_indication_q     = rpt_q[RPT_DI];
    mgmt_block_request_report_q   = rpt_q[RPT_BR];
    grading_indication_q          = rpt_q[RPT_GI];
    terminal_out_of_service_ind_q = rpt_q[RPT_UF];
    network_failure_ind_q         = rpt_q[RPT_NF];
  end

  // ****************************************************************
  // Transmit
  // ****************************************************************
  ipsf_tx_reg u_tx (
    .core_clk   (core_clk),
    .rst        (rst),
    .send       (send_d),
    .code       (code_d),
    .tx_valid_q (tx_valid),
    .tx_code_q  (tx_code)
  );

endmodule // ipsf_port_fsm
`default_nettype wire

//--- rtl/ipsf_defs.vh
// Control element codes, state codes and widths for the exchange-side port status machine
`ifndef IPSF_DEFS_VH
`define IPSF_DEFS_VH
`define IPSF_CFE_W            7
`define IPSF_CFE_ACT_ACCESS   7'h01
`define IPSF_CFE_USER_ACT     7'h02
`define IPSF_CFE_SECT_ACTED   7'h03
`define IPSF_CFE_ACC_ACTED    7'h04
`define IPSF_CFE_DEACT_ACCESS 7'h05
`define IPSF_CFE_ACC_DEACTED  7'h06
`define IPSF_CFE_UNBLOCK      7'h11
`define IPSF_CFE_BLOCK        7'h13
`define IPSF_CFE_BLOCK_REQ    7'h15
`define IPSF_CFE_GRADING      7'h16
`define IPSF_CFE_SIG_BLOCK    7'h17
`define IPSF_CFE_SIG_UNBLOCK  7'h18
`define IPSF_CFE_TE_OOS       7'h19
`define IPSF_CFE_NET_FAIL     7'h1A
`define IPSF_ST_W             4
`define IPSF_ST_BLOCKED       4'h1
`define IPSF_ST_LOCAL_UB      4'h2
`define IPSF_ST_REMOTE_UB     4'h4
`define IPSF_ST_OPER          4'h8
`endif

//--- rtl/ipsf_cfe_decode.v
// Decoder of received control function element codes into one-hot event strobes
`default_nettype none
`include "ipsf_defs.vh"
module ipsf_cfe_decode (
  // Received element
  input  wire                   rx_valid,
  input  wire [`IPSF_CFE_W-1:0] rx_code,
  // Decoded strobes
  output wire                   ev_unblock,
  output wire                   ev_block,
  output wire                   ev_block_req,
  output wire                   ev_grading,
  output wire                   ev_te_oos,
  output wire                   ev_net_fail,
  output wire                   ev_other
);
  // Known codes; anything else counts as reserved or foreign
  assign ev_unblock   = rx_valid && (rx_code == `IPSF_CFE_UNBLOCK);
  assign ev_block     = rx_valid && (rx_code == `IPSF_CFE_BLOCK);
  assign ev_block_req = rx_valid && (rx_code == `IPSF_CFE_BLOCK_REQ);
  assign ev_grading   = rx_valid && (rx_code == `IPSF_CFE_GRADING);
  assign ev_te_oos    = rx_valid && (rx_code == `IPSF_CFE_TE_OOS);
  assign ev_net_fail  = rx_valid && (rx_code == `IPSF_CFE_NET_FAIL);
  assign ev_other     = rx_valid && !(ev_unblock || ev_block || ev_block_req ||
                        ev_grading || ev_te_oos || ev_net_fail);
endmodule // ipsf_cfe_decode
`default_nettype wire

//--- rtl/ipsf_tx_reg.v
// Registered transmit stage for outgoing control function elements
`default_nettype none
`include "ipsf_defs.vh"
module ipsf_tx_reg (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   rst,
  // From state machine
  input  wire                   send,
  input  wire [`IPSF_CFE_W-1:0] code,
  // To message transport
  output reg                    tx_valid_q,
  output reg  [`IPSF_CFE_W-1:0] tx_code_q
);
  // One-cycle strobe with code held until the next send
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_valid_q <= 1'b0;
      tx_code_q  <= `IPSF_CFE_W'h00;
    end else begin
      tx_valid_q <= send;
      if (send) begin
        tx_code_q <= code;
      end
    end
  end
endmodule // ipsf_tx_reg
`default_nettype wire

//--- verif/ipsf_port_chk.sv
// Checker of the port status machine answers and element coding
`default_nettype none
module ipsf_port_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Inputs
  input wire logic       perf_mon_enable,
  input wire logic       mgmt_unblock_request,
  input wire logic       mgmt_block_indication,
  input wire logic       sig_channel_block_request,
  input wire logic       sig_channel_unblock_request,
  input wire logic       rx_valid,
  input wire logic [6:0] rx_code,
  // Outputs
  input wire logic       tx_valid,
  input wire logic [6:0] tx_code,
  input wire logic       mgmt_unblock_req_out_q,
  input wire logic       mgmt_block_ind_out_q,
  input wire logic       activation_indication_q,
  input wire logic       deactivation_indication_q,
  input wire logic       grading_indication_q,
  input wire logic [3:0] port_state
);
  // Events after the priority order
  wire mb = mgmt_block_indication;
  wire mu = mgmt_unblock_request & ~mb;
  wire ms = (sig_channel_block_request | sig_channel_unblock_request) & ~mb & ~mgmt_unblock_request;
  wire rv = rx_valid & ~mb & ~mgmt_unblock_request & ~sig_channel_block_request
            & ~sig_channel_unblock_request;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_mgmt_block_sends: assert property (mb |=> tx_valid && tx_code == 7'h13 && port_state == 4'h1)
    else $error("management block not carried out");
  a_unblock_always_sent: assert property (mu |=> tx_valid && tx_code == 7'h11)
    else $error("unblock element not sent");
  a_remote_to_oper: assert property (mu && port_state == 4'h4 |=> activation_indication_q && port_state == 4'h8)
    else $error("remote unblock not completed");
  a_rx_unblock_blocked: assert property (rv && rx_code == 7'h11 && port_state == 4'h1 |=> mgmt_unblock_req_out_q && port_state == 4'h4)
    else $error("received unblock in blocked mishandled");
  a_rx_block_oper: assert property (rv && rx_code == 7'h13 && port_state == 4'h8 |=> deactivation_indication_q && mgmt_block_ind_out_q && port_state == 4'h1)
    else $error("received block in operational mishandled");
  a_grading_no_move: assert property (rv && rx_code == 7'h16 && port_state == 4'h8 |=> grading_indication_q == $past(perf_mon_enable) && port_state == 4'h8)
    else $error("grading report mishandled");
  a_sig_oper_only: assert property (ms |=> tx_valid == ($past(port_state) == 4'h8) && (!tx_valid || tx_code == ($past(sig_channel_block_request) ? 7'h17 : 7'h18)))
    else $error("signalling channel request mishandled");
  a_tx_code_legal: assert property (tx_valid |-> tx_code inside {7'h11, 7'h13, 7'h17, 7'h18})
    else $error("reserved or foreign element sent");
  a_state_onehot: assert property ($onehot(port_state))
    else $error("state not one of four");
  a_act_enters_oper: assert property (activation_indication_q |-> port_state == 4'h8 && $past(port_state) inside {4'h2, 4'h4})
    else $error("activation without entering operational");
  c_oper: cover property (port_state == 4'h8);
  c_grading: cover property (grading_indication_q);
  c_sig_block: cover property (tx_valid && tx_code == 7'h17);
endmodule // ipsf_port_chk
bind ipsf_port_fsm ipsf_port_chk i_ipsf_port_chk (.core_clk, .rst, .perf_mon_enable,
  .mgmt_unblock_request, .mgmt_block_indication, .sig_channel_block_request,
  .sig_channel_unblock_request, .rx_valid, .rx_code, .tx_valid, .tx_code, .mgmt_unblock_req_out_q,
  .mgmt_block_ind_out_q, .activation_indication_q, .deactivation_indication_q,
  .grading_indication_q, .port_state);
`default_nettype wire

//--- verif/ipsf_peer_model.sv
// Access network peer model sending control elements to the exchange
`default_nettype none
module ipsf_peer_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Bench commands
  input  wire logic       cmd_valid,
  input  wire logic [6:0] cmd_code,
  input  wire logic       ans_en,
  input  wire logic [3:0] ans_dly,
  // Link to the exchange
  input  wire logic       tx_valid,
  input  wire logic [6:0] tx_code,
  output var  logic       rx_valid,
  output var  logic [6:0] rx_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       pend_q = 1'b0;
  logic [6:0] pcode_q = 7'h00;
  logic [4:0] ans_q = 5'h00;
  initial rx_valid = 1'b0;
  initial rx_code = 7'h00;
  // Take commands; answer an unblock after a chosen delay
  always @(posedge core_clk) begin
    pend_q  <= !rst && (cmd_valid || ans_q == 5'h01);
    pcode_q <= cmd_valid ? cmd_code : 7'h11;
    if (rst) ans_q <= 5'h00;
    else if (ans_en && tx_valid && tx_code == 7'h11) ans_q <= {1'b0, ans_dly};
    else if (ans_q != 5'h00) ans_q <= ans_q - 5'h01;
  end
  // Idle code lines show the inverse of the last value
  always @(negedge core_clk) begin
    rx_valid <= pend_q;
    rx_code  <= pend_q ? pcode_q : ~rx_code;
  end
endmodule // ipsf_peer_model
`default_nettype wire

//--- verif/ipsf_port_fsm_tb.sv
// Self-checking bench of the exchange-side port status machine
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module ipsf_port_fsm_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, rst = 1'b1, pm = 1'b0, mu = 1'b0, mb = 1'b0, sb = 1'b0, su = 1'b0;
  logic        cv = 1'b0, ae = 1'b0, rx_valid, tx_valid;
  logic [6:0]  cc = 7'h00, rx_code, tx_code, last_tx = 7'h00;
  logic [8:0]  o;
  logic [3:0]  port_state, st = 4'h1;
  logic [11:0] cor[18] = '{12'h100, 12'h411, 12'h416, 12'h415, 12'h419, 12'h200, 12'h300,
    12'h100, 12'h411, 12'h413, 12'h413, 12'h419, 12'h41A, 12'h411, 12'h100, 12'h400, 12'h47F, 12'h000};
  int          fails = 0, n_tests = 0;
  ipsf_port_fsm i_ipsf_port_fsm (.core_clk, .rst, .perf_mon_enable(pm), .mgmt_unblock_request(mu),
    .mgmt_block_indication(mb), .sig_channel_block_request(sb), .sig_channel_unblock_request(su),
    .rx_valid, .rx_code, .tx_valid, .tx_code, .mgmt_unblock_req_out_q(o[8]), .mgmt_block_ind_out_q(o[7]),
    .mgmt_unblock_indication_q(o[6]), .activation_indication_q(o[5]), .deactivation_indication_q(o[4]),
    .mgmt_block_request_report_q(o[3]), .grading_indication_q(o[2]),
    .terminal_out_of_service_ind_q(o[1]), .network_failure_ind_q(o[0]), .port_state);
  ipsf_peer_model i_ipsf_peer_model (.core_clk, .rst, .cmd_valid(cv), .cmd_code(cc), .ans_en(ae),
    .ans_dly(4'h5), .tx_valid, .tx_code, .rx_valid, .rx_code);
  always #50 core_clk = ~core_clk;
  // Expected {tx_valid, tx_code, reports, state} for event k (4 means a received code c)
  function automatic logic [20:0] ref_fn(input int k, input logic [6:0] c);
    logic tv = 1'b1;
    logic [6:0] tc = last_tx;
    logic [8:0] r = 9'h000;
    logic [3:0] s = st;
    case (k)
      0: begin tc = 7'h13; s = 4'h1; end
      1: begin tc = 7'h11; s = st == 4'h1 ? 4'h2 : st == 4'h4 ? 4'h8 : st; r[5] = st == 4'h4; end
      2, 3: begin tv = st == 4'h8; if (tv) tc = k == 2 ? 7'h17 : 7'h18; end
      default: begin
        tv = 1'b0;
        case (c)
          7'h11: begin r[8] = st[0] | st[2]; r[5] = st[1]; r[6] = st[3]; s = st[0] ? 4'h4 : st[1] ? 4'h8 : st; end
          7'h13: begin r[7] = !st[0]; r[4] = st[3]; s = 4'h1; end
          7'h15: r[3] = st[3];
          7'h16: r[2] = st[3] & pm;
          7'h19: r[1] = st[0] | st[1];
          7'h1A: r[0] = st[0] | st[1];
          default: ;
        endcase
      end
    endcase
    return {tv, tc, r, s};
  endfunction
  // One event, checked in the cycle its answer stands
  task automatic step(input int k, input logic [6:0] c);
    logic [20:0] e;
    @(negedge core_clk);
    pm = $urandom;
    {mb, mu, sb, su, cv} = 5'b10000 >> k;
    cc = c;
    e = ref_fn(k, c);
    @(negedge core_clk);
    {mb, mu, sb, su, cv} = 5'b00000;
    if (k == 4) @(negedge core_clk);
    `CHK("ports", e, {tx_valid, tx_code, o, port_state})
    st = e[3:0];
    last_tx = e[19:13];
  endtask
  task automatic wait_for(input int b);
    int i;
    for (i = 0; i < 20 && o[b] !== 1'b1; i++) @(negedge core_clk);
    if (i == 20) begin fails++; $display("mismatch wait exp 1 got 0"); tally_and_finish(); end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(50));
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    `CHK("reset", 21'h00001, {tx_valid, tx_code, o, port_state})
    foreach (cor[i]) step(cor[i][11:8], cor[i][6:0]);
    $display("test corners done");
    step(0, 7'h00);
    ae = 1'b1;
    step(1, 7'h00);
    wait_for(5);
    `CHK("align", 4'h8, port_state)
    st = 4'h8;
    step(1, 7'h00);
    wait_for(6);
    `CHK("confirm", 4'h8, port_state)
    ae = 1'b0;
    st = 4'h8;
    $display("test align done");
    rst = 1'b1;
    @(negedge core_clk) rst = 1'b0;
    `CHK("reset2", 11'h001, {tx_code, port_state})
    st = 4'h1;
    last_tx = 7'h00;
    repeat (400) step($urandom_range(4, 0), $urandom);
    $display("test random done");
    tally_and_finish();
  end
endmodule // ipsf_port_fsm_tb
`default_nettype wire
